/* verilog/fcs_map.vh */
`ifndef FCS_MAP_VH
`define FCS_MAP_VH
`define FCS_UNLOCK_ADDR1 15'h5555
`define FCS_UNLOCK_ADDR2 15'h2AAA
`define FCS_UNLOCK_DATA1 8'hAA
`define FCS_UNLOCK_DATA2 8'h55
`define FCS_CMD_PROGRAM 8'hA0
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_ID_ENTRY 8'h90
`define FCS_CMD_ID_EXIT 8'hF0
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_PAGE_ERASE 8'h50
`define FCS_ID_MAKER_ADDR 8'h00
`define FCS_ID_PART_ADDR 8'h01
`define FCS_OP_NONE 3'h0
`define FCS_OP_PROGRAM 3'h1
`define FCS_OP_CHIP_ERASE 3'h2
`define FCS_OP_PAGE_ERASE 3'h3
`define FCS_OP_ID_ENTRY 3'h4
`define FCS_OP_ID_EXIT 3'h5
`define FCS_OP_ID_EXIT_SHORT 3'h6
`define FCS_OP_READ 3'h7
`define FCS_POLL_BIT 7
`define FCS_TOGGLE_BIT 6
`define FCS_SETUP_NS 50
`define FCS_STROBE_NS 100
`define FCS_HOLD_NS 50
`define FCS_CLK_NS 25
`endif

/* verilog/fcs_bus_cycle.v */
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_bus_cycle #(
   parameter AW = 17,
   parameter SETUP_CYC = (`FCS_SETUP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS,
   parameter STROBE_CYC = (`FCS_STROBE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS,
   parameter HOLD_CYC = (`FCS_HOLD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_start,
   input wire i_write,
   input wire [AW-1:0] i_addr,
   input wire [7:0] i_wdata,
   output reg o_busy,
   output reg o_done,
   output reg [7:0] o_rdata,
   output reg o_ce_n,
   output reg o_oe_n,
   output reg o_we_n,
   output reg [AW-1:0] o_addr,
   output reg [7:0] o_dq_out,
   output reg o_dq_oe_n,
   input wire [7:0] i_dq_in
);
   localparam S_IDLE = 4'b0001;
   localparam S_SETUP = 4'b0010;
   localparam S_STROBE = 4'b0100;
   localparam S_HOLD = 4'b1000;
   reg [3:0] state_r;
   reg [7:0] cnt_r;
   reg wr_r;
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      if (!i_rstn) begin
         state_r <= S_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
         o_busy <= 1'b0;
         o_rdata <= 8'h00;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_addr <= {AW{1'b0}};
         o_dq_out <= 8'h00;
         o_dq_oe_n <= 1'b1;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (i_start) begin
                  // Address settles with chip select before the strobe falls
                  o_addr <= i_addr;
                  o_dq_out <= i_wdata;
                  wr_r <= i_write;
                  o_ce_n <= 1'b0;
                  o_oe_n <= 1'b1;
                  o_dq_oe_n <= ~i_write;
                  o_busy <= 1'b1;
                  cnt_r <= SETUP_CYC[7:0];
                  state_r <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_r <= 8'h01) begin
                  if (wr_r)
                     o_we_n <= 1'b0;
                  else
                     o_oe_n <= 1'b0;
                  cnt_r <= STROBE_CYC[7:0];
                  state_r <= S_STROBE;
               end else
                  cnt_r <= cnt_r - 8'h01;
            end
            S_STROBE: begin
               if (cnt_r <= 8'h01) begin
                  // Write strobe rises first so data is taken on it
                  if (!wr_r)
                     o_rdata <= i_dq_in;
                  o_we_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  cnt_r <= HOLD_CYC[7:0];
                  state_r <= S_HOLD;
               end else
                  cnt_r <= cnt_r - 8'h01;
            end
            S_HOLD: begin
               if (cnt_r <= 8'h01) begin
                  // Deselect between cycles; the toggle bit advances on the falling read strobe
                  o_ce_n <= 1'b1;
                  o_dq_oe_n <= 1'b1;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  state_r <= S_IDLE;
               end else
                  cnt_r <= cnt_r - 8'h01;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule

/* verilog/fcs_host.v */
`timescale 1ns/1ps
`include "fcs_map.vh"
// Overview of operation
// - Identification lasts until the exit sequence is written.
// - Byte program is two unlock writes, A0 set-up, then address and data.
// - Program done when poll bit equals written value; poll at target address.
// - Chip erase is six writes: unlock, 80, unlock, 10.
// - Poll status valid after last erase strobe; poll inside erased page.
// - Poll bit may go valid early; reread for the full byte.
// - Command addresses use fifteen low bits; unlock 5555 then 2AAA.
// - A single F0 write at any address leaves identification.
module fcs_host #(
   parameter AW = 17
) (
   input wire i_clk,
   input wire i_rstn,
   input wire i_op_valid,
   input wire [2:0] i_op,
   input wire [AW-1:0] i_op_addr,
   input wire [7:0] i_op_data,
   output reg o_op_ready,
   output reg o_op_done,
   output reg o_op_fail,
   output reg [7:0] o_op_rdata,
   output reg o_ce_n,
   output reg o_oe_n,
   output reg o_we_n,
   output reg [AW-1:0] o_addr,
   output reg [7:0] o_data_lines_out,
   output reg o_data_lines_oe_n,
   input wire [7:0] i_data_lines_in
);
   localparam S_IDLE = 6'b000001;
   localparam S_ISSUE = 6'b000010;
   localparam S_WAIT = 6'b000100;
   localparam S_POLL = 6'b001000;
   localparam S_REREAD = 6'b010000;
   localparam S_FINISH = 6'b100000;
   reg [5:0] state_r;
   reg [2:0] op_r;
   reg [AW-1:0] addr_r;
   reg [7:0] data_r;
   reg [2:0] step_r;
   reg [2:0] nsteps_r;
   reg bc_start_r;
   reg bc_write_r;
   reg [AW-1:0] bc_addr_r;
   reg [7:0] bc_wdata_r;
   reg have_prev_r;
   reg prev_toggle_r;
   wire bc_busy;
   wire bc_done;
   wire [7:0] bc_rdata;
   wire bc_ce_n;
   wire bc_oe_n;
   wire bc_we_n;
   wire [AW-1:0] bc_addr;
   wire [7:0] bc_dq_out;
   wire bc_dq_oe_n;

   // Number of bus cycles in each command sequence
   function [2:0] seq_len;
      input [2:0] op;
      begin
         case (op)
            `FCS_OP_PROGRAM: seq_len = 3'd4;
            `FCS_OP_CHIP_ERASE: seq_len = 3'd6;
            `FCS_OP_PAGE_ERASE: seq_len = 3'd6;
            `FCS_OP_ID_ENTRY: seq_len = 3'd3;
            `FCS_OP_ID_EXIT: seq_len = 3'd3;
            default: seq_len = 3'd1;
         endcase
      end
   endfunction

   // Address of a command cycle; unlock addresses on the low fifteen bits
   function [AW-1:0] step_addr;
      input [2:0] step;
      input [2:0] op;
      input [AW-1:0] a;
      begin
         step_addr = {{(AW-15){1'b0}}, `FCS_UNLOCK_ADDR1};
         if (step == 3'd1 || step == 3'd4)
            step_addr = {{(AW-15){1'b0}}, `FCS_UNLOCK_ADDR2};
         else if (op == `FCS_OP_READ || op == `FCS_OP_ID_EXIT_SHORT)
            step_addr = a;
         else if (op == `FCS_OP_PROGRAM && step == 3'd3)
            step_addr = a;
         else if (op == `FCS_OP_PAGE_ERASE && step == 3'd5)
            step_addr = a;
      end
   endfunction

   function [7:0] step_data;
      input [2:0] step;
      input [2:0] op;
      input [7:0] d;
      begin
         case (step)
            3'd0: step_data = `FCS_UNLOCK_DATA1;
            3'd1: step_data = `FCS_UNLOCK_DATA2;
            3'd3: step_data = (op == `FCS_OP_PROGRAM) ? d : `FCS_UNLOCK_DATA1;
            3'd4: step_data = `FCS_UNLOCK_DATA2;
            3'd5: step_data = (op == `FCS_OP_CHIP_ERASE) ? `FCS_CMD_CHIP_ERASE
                              : `FCS_CMD_PAGE_ERASE;
            default: begin
               case (op)
                  `FCS_OP_PROGRAM: step_data = `FCS_CMD_PROGRAM;
                  `FCS_OP_ID_ENTRY: step_data = `FCS_CMD_ID_ENTRY;
                  `FCS_OP_ID_EXIT: step_data = `FCS_CMD_ID_EXIT;
                  default: step_data = `FCS_CMD_ERASE_SETUP;
               endcase
            end
         endcase
         if (step == 3'd0 && op == `FCS_OP_ID_EXIT_SHORT)
            step_data = `FCS_CMD_ID_EXIT;
      end
   endfunction

   fcs_bus_cycle #(.AW(AW)) u_bus (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_start(bc_start_r),
      .i_write(bc_write_r),
      .i_addr(bc_addr_r),
      .i_wdata(bc_wdata_r),
      .o_busy(bc_busy),
      .o_done(bc_done),
      .o_rdata(bc_rdata),
      .o_ce_n(bc_ce_n),
      .o_oe_n(bc_oe_n),
      .o_we_n(bc_we_n),
      .o_addr(bc_addr),
      .o_dq_out(bc_dq_out),
      .o_dq_oe_n(bc_dq_oe_n),
      .i_dq_in(i_data_lines_in)
   );

   wire is_erase = (op_r == `FCS_OP_CHIP_ERASE) || (op_r == `FCS_OP_PAGE_ERASE);
   wire poll_ok = is_erase ? bc_rdata[`FCS_POLL_BIT]
                  : (bc_rdata[`FCS_POLL_BIT] == data_r[`FCS_POLL_BIT]);
   wire toggled = bc_rdata[`FCS_TOGGLE_BIT] != prev_toggle_r;

   always @(posedge i_clk) begin
      bc_start_r <= 1'b0;
      o_op_done <= 1'b0;
      // Pins mirror the cycle engine through one more flop
      o_ce_n <= bc_ce_n;
      o_oe_n <= bc_oe_n;
      o_we_n <= bc_we_n;
      o_addr <= bc_addr;
      o_data_lines_out <= bc_dq_out;
      o_data_lines_oe_n <= bc_dq_oe_n;
      if (!i_rstn) begin
         state_r <= S_IDLE;
         op_r <= `FCS_OP_NONE;
         addr_r <= {AW{1'b0}};
         data_r <= 8'h00;
         step_r <= 3'd0;
         nsteps_r <= 3'd1;
         bc_write_r <= 1'b0;
         bc_addr_r <= {AW{1'b0}};
         bc_wdata_r <= 8'h00;
         have_prev_r <= 1'b0;
         prev_toggle_r <= 1'b0;
         o_op_ready <= 1'b0;
         o_op_fail <= 1'b0;
         o_op_rdata <= 8'h00;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_addr <= {AW{1'b0}};
         o_data_lines_out <= 8'h00;
         o_data_lines_oe_n <= 1'b1;
      end else begin
         case (state_r)
            S_IDLE: begin
               o_op_ready <= 1'b1;
               if (i_op_valid && o_op_ready) begin
                  o_op_ready <= 1'b0;
                  o_op_fail <= 1'b0;
                  op_r <= i_op;
                  addr_r <= i_op_addr;
                  data_r <= i_op_data;
                  step_r <= 3'd0;
                  nsteps_r <= seq_len(i_op);
                  state_r <= S_ISSUE;
               end
            end
            S_ISSUE: begin
               // Reads need no preceding command
               bc_start_r <= 1'b1;
               bc_write_r <= (op_r != `FCS_OP_READ);
               bc_addr_r <= step_addr(step_r, op_r, addr_r);
               bc_wdata_r <= step_data(step_r, op_r, data_r);
               state_r <= S_WAIT;
            end
            S_WAIT: begin
               if (bc_done) begin
                  if (step_r + 3'd1 < nsteps_r) begin
                     step_r <= step_r + 3'd1;
                     state_r <= S_ISSUE;
                  end else if (op_r == `FCS_OP_PROGRAM || is_erase) begin
                     // No command is written until the device is idle again
                     have_prev_r <= 1'b0;
                     bc_start_r <= 1'b1;
                     bc_write_r <= 1'b0;
                     bc_addr_r <= addr_r;
                     state_r <= S_POLL;
                  end else begin
                     o_op_rdata <= bc_rdata;
                     state_r <= S_FINISH;
                  end
               end
            end
            S_POLL: begin
               if (bc_done) begin
                  have_prev_r <= 1'b1;
                  prev_toggle_r <= bc_rdata[`FCS_TOGGLE_BIT];
                  if (poll_ok) begin
                     bc_start_r <= 1'b1;
                     state_r <= S_REREAD;
                  end else if (have_prev_r && !toggled) begin
                     o_op_fail <= 1'b1;
                     o_op_rdata <= bc_rdata;
                     state_r <= S_FINISH;
                  end else
                     bc_start_r <= 1'b1;
               end
            end
            S_REREAD: begin
               if (bc_done) begin
                  o_op_rdata <= bc_rdata;
                  if (op_r == `FCS_OP_PROGRAM && bc_rdata != data_r)
                     o_op_fail <= 1'b1;
                  state_r <= S_FINISH;
               end
            end
            S_FINISH: begin
               o_op_done <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule

/* verification/fcs_host_sva.sv */
`timescale 1ns/1ps
module fcs_host_sva #(
   parameter AW = 17
) (
   input logic i_clk,
   input logic i_rstn,
   input logic i_op_valid,
   input logic [2:0] i_op,
   input logic o_op_ready,
   input logic o_op_done,
   input logic o_ce_n,
   input logic o_oe_n,
   input logic o_we_n,
   input logic [AW-1:0] o_addr,
   input logic [7:0] o_data_lines_out,
   input logic o_data_lines_oe_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   write_gate_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
      else $error("write strobe without select or with output gate low");
   bus_clash_a: assert property (!o_oe_n |-> o_data_lines_oe_n)
      else $error("host drives data while device outputs are enabled");
   write_hold_a: assert property (!o_we_n && $past(!o_we_n) |->
      $stable(o_addr) && $stable(o_data_lines_out) && !o_data_lines_oe_n)
      else $error("address or data moved during write strobe");
   write_width_a: assert property ($fell(o_we_n) |-> !o_we_n[*4] ##[1:3] o_we_n)
      else $error("write strobe width wrong");
   read_width_a: assert property ($fell(o_oe_n) |-> !o_oe_n[*4] ##[1:3] o_oe_n)
      else $error("read strobe width wrong");
   select_setup_a: assert property ($fell(o_we_n) |-> $past(o_ce_n, 2) == 1'b0)
      else $error("chip select not set up before write strobe");
   idle_quiet_a: assert property (o_op_ready |-> o_ce_n && o_oe_n && o_we_n)
      else $error("bus active while idle");
   done_pulse_a: assert property (o_op_done |=> !o_op_done)
      else $error("done longer than one cycle");
   unlock_first_a: assert property (i_op_valid && o_op_ready && i_op == 3'h1 |->
      o_we_n[*2] ##[1:12] (!o_we_n && o_addr[14:0] == 15'h5555 && o_data_lines_out == 8'hAA))
      else $error("program does not open with first unlock write");
endmodule
bind fcs_host fcs_host_sva #(.AW(AW)) i_fcs_host_sva (.i_clk(i_clk), .i_rstn(i_rstn),
   .i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
   .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr),
   .o_data_lines_out(o_data_lines_out), .o_data_lines_oe_n(o_data_lines_oe_n));

/* verification/fcs_flash_model.sv */
`timescale 1ns/1ps
module fcs_flash_model #(
   parameter AW = 17,
   parameter MAKER_ID = 8'h5A, // Arbitrary identity value
   parameter PART_ID = 8'hC3, // Arbitrary identity value
   parameter BUSY_NS = 3000
) (
   input wire i_ce_n,
   input wire i_oe_n,
   input wire i_we_n,
   input wire [AW-1:0] i_addr,
   input wire [7:0] i_dq,
   output logic [7:0] o_dq
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [AW-1:0] la;
   logic [7:0] last = 8'h00;
   logic [7:0] wd = 8'h00;
   int step = 0;
   bit ers = 0, tog = 0;
   bit idm = 0;
   realtime busy_end = 0;
   initial foreach (mem[i]) mem[i] = 8'hFF;
   function automatic bit busy();
      return $realtime < busy_end;
   endfunction
   task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
      logic [14:0] c;
      c = a[14:0];
      if (busy()) return;
      if (idm && step == 0 && d == 8'hF0) begin
         idm = 0;
         return;
      end
      case (step)
         0, 3: step = (c == 15'h5555 && d == 8'hAA) ? step + 1 : 0;
         1, 4: step = (c == 15'h2AAA && d == 8'h55) ? step + 1 : 0;
         2: begin
            step = 0;
            if (c == 15'h5555 && d == 8'hA0) step = 6;
            if (c == 15'h5555 && d == 8'h80) step = 3;
            if (c == 15'h5555 && d == 8'h90) idm = 1;
            if (c == 15'h5555 && d == 8'hF0) idm = 0;
         end
         6: begin
            step = 0;
            wd = d;
            ers = 0;
            busy_end = ((mem[a] & d) != d) ? $realtime : $realtime + BUSY_NS;
            mem[a] = mem[a] & d;
         end
         default: begin
            step = 0;
            if (c == 15'h5555 && d == 8'h10) foreach (mem[i]) mem[i] = 8'hFF;
            if (d == 8'h50) for (int i = 0; i < 4096; i++) mem[{a[AW-1:12], 12'(i)}] = 8'hFF;
            if ((c == 15'h5555 && d == 8'h10) || d == 8'h50) begin
               ers = 1;
               busy_end = $realtime + BUSY_NS;
            end
         end
      endcase
   endtask
   always @(negedge i_ce_n or negedge i_we_n) la = i_addr;
   always @(posedge i_we_n or posedge i_ce_n) if (i_oe_n && !(i_we_n && i_ce_n)) wr(la, i_dq);
   // One toggle per read: only the edge that completes select and gate counts
   always @(negedge i_oe_n or negedge i_ce_n)
      if (busy() && !i_ce_n && !i_oe_n) tog = !tog;
   always @* begin
      if (!i_ce_n && !i_oe_n) begin
         if (busy()) last = {ers ? 1'b0 : ~wd[7], tog, 6'h15};
         else if (idm && i_addr[7:1] == 7'h00) last = i_addr[0] ? PART_ID : MAKER_ID;
         else last = mem[i_addr];
         o_dq = last;
      end else begin
         o_dq = ~last;
      end
   end
endmodule

/* verification/flash_command_sequencer_tb.sv */
`timescale 1ns/1ps
module flash_command_sequencer_tb;
   localparam logic [7:0] MAKER = 8'h6B; // Arbitrary identity value
   localparam logic [7:0] PART = 8'h94; // Arbitrary identity value
   logic clk = 0, rstn = 0, vld = 0;
   logic [2:0] op = 0;
   logic [16:0] oa = 0, a, b;
   logic [7:0] od = 0, d;
   wire rdy, done, fail, ce_n, oe_n, we_n, doe_n;
   wire [16:0] addr;
   wire [7:0] rd, dout, dev_q;
   wire [7:0] dq = doe_n ? dev_q : dout;
   int mismatches = 0, checks = 0, seed = 32'he66c5ed6;
   logic [7:0] ref_mem [0:131071];
   initial forever #12.5 clk = ~clk;
   fcs_host #(.AW(17)) i_fcs_host (.i_clk(clk), .i_rstn(rstn), .i_op_valid(vld), .i_op(op),
      .i_op_addr(oa), .i_op_data(od), .o_op_ready(rdy), .o_op_done(done), .o_op_fail(fail),
      .o_op_rdata(rd), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr),
      .o_data_lines_out(dout), .o_data_lines_oe_n(doe_n), .i_data_lines_in(dq));
   fcs_flash_model #(.AW(17), .MAKER_ID(MAKER), .PART_ID(PART)) i_fcs_flash_model (
      .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr), .i_dq(dq), .o_dq(dev_q));
   task automatic stop_test();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(inout int n);
      @(negedge clk);
      n++;
      if (n > 20000) begin
         mismatches++;
         stop_test();
      end
   endtask
   // One operation through the request handshake; read data only where defined
   task automatic run(input logic [2:0] o, input logic [16:0] ra, input logic [7:0] rw,
         input bit chk, input logic [7:0] exp, input logic efail);
      int n;
      n = 0;
      while (rdy !== 1'b1) tick(n);
      op = o;
      oa = ra;
      od = rw;
      vld = 1;
      @(negedge clk);
      vld = 0;
      n = 0;
      while (done !== 1'b1) tick(n);
      if (chk) cmp(rd, exp);
      cmp({7'h00, fail}, {7'h00, efail});
   endtask
   task automatic prog(input logic [16:0] pa, input logic [7:0] pd);
      logic [7:0] old;
      old = ref_mem[pa];
      ref_mem[pa] = old & pd;
      run(3'h1, pa, pd, 1, old & pd, (old & pd) != pd);
      run(3'h7, pa, 8'h00, 1, ref_mem[pa], 0);
   endtask
   initial begin
      foreach (ref_mem[i]) ref_mem[i] = 8'hFF;
      repeat (5) @(negedge clk);
      rstn = 1;
      run(3'h7, 17'h1F00F, 8'h00, 1, 8'hFF, 0);
      for (int i = 0; i < 6; i++) begin
         a = 17'($random(seed));
         d = 8'($random(seed));
         prog(a, d);
      end
      prog(a, 8'h3C);
      prog(a, 8'hC3);
      run(3'h4, 17'h0, 8'h00, 0, 8'h00, 0);
      run(3'h7, {a[16:8], 8'h00}, 8'h00, 1, MAKER, 0);
      run(3'h7, {a[16:8], 8'h01}, 8'h00, 1, PART, 0);
      run(3'h5, 17'h0, 8'h00, 0, 8'h00, 0);
      run(3'h7, a, 8'h00, 1, ref_mem[a], 0);
      run(3'h4, 17'h0, 8'h00, 0, 8'h00, 0);
      run(3'h6, 17'($random(seed)), 8'h00, 0, 8'h00, 0);
      run(3'h7, {a[16:8], 8'h00}, 8'h00, 1, ref_mem[{a[16:8], 8'h00}], 0);
      b = a ^ 17'h10000;
      prog(b, 8'h5A);
      run(3'h3, a, 8'h00, 1, 8'hFF, 0);
      for (int i = 0; i < 4096; i++) ref_mem[{a[16:12], 12'(i)}] = 8'hFF;
      run(3'h7, a ^ 17'h00FF0, 8'h00, 1, 8'hFF, 0);
      run(3'h7, b, 8'h00, 1, ref_mem[b], 0);
      run(3'h2, b, 8'h00, 1, 8'hFF, 0);
      run(3'h7, b, 8'h00, 1, 8'hFF, 0);
      run(3'h7, 17'($random(seed)), 8'h00, 1, 8'hFF, 0);
      stop_test();
   end
endmodule
